// ### rtl/ssd_cfg.svh
// Constants of the safety sensor diagnostics block: offsets, bit positions, timing
`ifndef SSD_CFG_SVH
`define SSD_CFG_SVH

// Clock and timing
`define CLK_HZ          50000000
`define SHUTDOWN_MIN    30
`define SHUTDOWN_CYC    (64'(`SHUTDOWN_MIN) * 64'd60 * 64'(`CLK_HZ))
`define FLASH_PULSE_MS  200
`define FLASH_GAP_MS    1000
`define TOGGLE_MS       500
`define FLASH_PULSE_CYC (`FLASH_PULSE_MS * (`CLK_HZ / 1000))
`define FLASH_GAP_CYC   (`FLASH_GAP_MS * (`CLK_HZ / 1000))
`define TOGGLE_CYC      (`TOGGLE_MS * (`CLK_HZ / 1000))
`define TMR_W           40
`define CNT_W           28
`define CHAIN_MAX       31

// Register offsets (byte addresses)
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_WARN        8'h08
`define REG_ISTAT       8'h0c
`define REG_IMASK       8'h10
`define REG_REQ         8'h14
`define CTRL_FRST       0

// Response byte bits
`define RSP_SAFE        0
`define RSP_ACT         1
`define RSP_INP         4
`define RSP_LIM         5
`define RSP_WARN        6
`define RSP_FAIL        7
`define REQ_FRST        7

// Warning/failure byte bits
`define WF_ERR_A        0
`define WF_ERR_B        1
`define WF_CROSS        2
`define WF_TEMP         3
`define WF_ACTR         4
`define WF_INTL         5
`define WF_COMM         6

// Red flash codes
`define CODE_OFF        3'h0
`define CODE_ERR_A      3'h1
`define CODE_ERR_B      3'h2
`define CODE_CROSS      3'h3
`define CODE_TEMP       3'h4
`define CODE_ACTR       3'h5
`define CODE_STEADY     3'h7

// Interrupt status bits
`define IRQ_W           4
`define IRQ_WARN        0
`define IRQ_FAIL        1
`define IRQ_LIMIT       2
`define IRQ_FRST        3

`endif

// ### rtl/ssd_pkg.sv
// Types of the safety sensor diagnostics block
package ssd_pkg;
  `include "ssd_cfg.svh"

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RUN  = 4'b0010,
    ST_WARN = 4'b0100,
    ST_FAIL = 4'b1000
  } run_state_t;

  typedef struct packed {
    run_state_t         st;
    logic [`TMR_W-1:0]  tmr;
    logic [`CNT_W-1:0]  tog_cnt;
    logic               tog;
    logic               lim_seen;
    logic               safe;
    logic               diag;
    logic               green;
    logic               yellow;
    logic [2:0]         code;
    logic [7:0]         resp;
    logic [7:0]         wf;
    logic [7:0]         req_last;
    logic [`IRQ_W-1:0]  irq_stat;
    logic [`IRQ_W-1:0]  irq_mask;
    logic               irq;
    logic               pready;
    logic               pslverr;
    logic [31:0]        prdata;
  } core_state_t;

  typedef struct packed {
    logic               on;
    logic [2:0]         idx;
    logic [`CNT_W-1:0]  cnt;
  } flash_state_t;
endpackage

// ### rtl/flash_gen.sv
// Pulse-group generator for the red indicator flash codes
`timescale 1ns/1ns
`include "ssd_cfg.svh"
module flash_gen import ssd_pkg::*; #(
  parameter logic [`CNT_W-1:0] PULSE_CYC = `CNT_W'(`FLASH_PULSE_CYC),
  parameter logic [`CNT_W-1:0] GAP_CYC   = `CNT_W'(`FLASH_GAP_CYC)
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // Code in, lamp out
  input  wire logic [2:0] code,
  output logic            led
);
  flash_state_t q;
  flash_state_t d;

  // Code 0 is dark, 7 steady, others give that many pulses then a gap
  always_comb begin
    d = q;
    if (code == `CODE_OFF || code == `CODE_STEADY) begin
      d.on  = (code == `CODE_STEADY);
      d.idx = 3'h0;
      d.cnt = '0;
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - 1'b1;
    end else if (q.on) begin
      d.on  = 1'b0;
      d.idx = q.idx + 3'h1;
      d.cnt = (q.idx + 3'h1 >= code) ? GAP_CYC : PULSE_CYC;
    end else begin
      d.on  = 1'b1;
      d.idx = (q.idx >= code) ? 3'h0 : q.idx;
      d.cnt = PULSE_CYC;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign led = q.on;
endmodule

// ### rtl/safety_sensor_diagnostics.sv
// Diagnostic, indicator and shutdown logic of a non-contact safety sensor
//
// Contract
// - Green lit when ready and powered
// - Yellow steady in range, flashing near limit
// - Red pulses give cause code, steady internal
// - Fault drops diag now, outputs off later
// - Warning: diag low, safety channels still on
// - Limit area: diag cycles, channels stay on
// - No actuator: outputs off, green only
// - Internal failure: red, yellow, all outputs off
// - Chain of up to 31 sensors
// - Status byte bit layout
// - Warning/failure byte bit layout
// - All status bits active high
// - Response bytes refreshed continuously, unpolled
// - Status bit combinations per operating condition
`timescale 1ns/1ns
`include "ssd_cfg.svh"
module safety_sensor_diagnostics import ssd_pkg::*; #(
  parameter logic [`TMR_W-1:0] SHUTDOWN_CYC = `TMR_W'(`SHUTDOWN_CYC),
  parameter logic [`CNT_W-1:0] PULSE_CYC    = `CNT_W'(`FLASH_PULSE_CYC),
  parameter logic [`CNT_W-1:0] GAP_CYC      = `CNT_W'(`FLASH_GAP_CYC),
  parameter logic [`CNT_W-1:0] TOGGLE_CYC   = `CNT_W'(`TOGGLE_CYC)
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  // Sensing and self-test conditions
  input  wire logic        actuator_present,
  input  wire logic        limit_area,
  input  wire logic        safety_in_a,
  input  wire logic        safety_in_b,
  input  wire logic        err_out_a,
  input  wire logic        err_out_b,
  input  wire logic        cross_wire,
  input  wire logic        over_temp,
  input  wire logic        bad_actuator,
  input  wire logic        internal_fail,
  input  wire logic        comm_err,
  // Serial diagnostic chain
  input  wire logic [4:0]  chain_pos,
  input  wire logic        req_valid,
  input  wire logic [4:0]  req_addr,
  input  wire logic [7:0]  req_byte,
  output logic [7:0]       resp_byte,
  output logic [7:0]       wf_byte,
  // Indicators and output stages
  output logic             green_led,
  output logic             red_led,
  output logic             yellow_led,
  output logic             diag_out,
  output logic             safety_out_a,
  output logic             safety_out_b
);
  core_state_t         q;
  core_state_t         d;
  logic                fault;
  logic                hard;
  logic                act_ok;
  logic                wr;
  logic                req_hit;
  logic                frst;
  logic                live;
  logic                run;
  logic [`IRQ_W-1:0]   ev;
  logic [`IRQ_W-1:0]   clr;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    d      = q;
    fault  = err_out_a | err_out_b | cross_wire | over_temp;
    hard   = internal_fail | bad_actuator;
    act_ok = actuator_present & safety_in_a & safety_in_b;
    wr     = psel & penable & q.pready & pwrite;
    // Only the addressed position in a chain of at most 31 accepts a request
    req_hit = req_valid && (req_addr == chain_pos) && (chain_pos != 5'h0)
              && (32'(chain_pos) <= `CHAIN_MAX);
    frst   = (wr && paddr == `REG_CTRL && pwdata[`CTRL_FRST])
             || (req_hit && req_byte[`REQ_FRST]);

    // Operating state; a warnable fault only starts the shutdown delay
    unique case (q.st)
      ST_IDLE: begin
        if (hard) d.st = ST_FAIL;
        else if (fault) d.st = ST_WARN;
        else if (act_ok) d.st = ST_RUN;
      end
      ST_RUN: begin
        if (hard) d.st = ST_FAIL;
        else if (fault) d.st = ST_WARN;
        else if (!actuator_present) d.st = ST_IDLE;
      end
      ST_WARN: begin
        if (hard) d.st = ST_FAIL;
        else if (!fault) d.st = ST_IDLE;
        else if (q.tmr == SHUTDOWN_CYC - 1'b1) d.st = ST_FAIL;
      end
      ST_FAIL: begin
        // Latched: needs a reset request and every cause gone
        if (frst && !fault && !hard) d.st = ST_IDLE;
      end
    endcase
    d.tmr = (d.st == ST_WARN && q.st == ST_WARN) ? q.tmr + 1'b1 : '0;

    // Free-running toggle for the limit-area blink
    if (q.tog_cnt >= TOGGLE_CYC - 1'b1) begin
      d.tog_cnt = '0;
      d.tog     = ~q.tog;
    end else begin
      d.tog_cnt = q.tog_cnt + 1'b1;
    end

    // Output stages and indicators
    run      = (d.st == ST_RUN);
    live     = (d.st == ST_RUN) || (d.st == ST_WARN);
    d.safe   = live & act_ok & ~hard;
    d.diag   = run & act_ok & (~limit_area | q.tog);
    d.green  = (d.st == ST_IDLE || d.st == ST_RUN) & ~internal_fail;
    d.yellow = internal_fail
               | (actuator_present & (~(run & limit_area) | q.tog));

    // Red cause code; internal failure gives steady red, otherwise the lowest-numbered cause wins when several are present
    if (internal_fail) d.code = `CODE_STEADY;
    else if (d.st != ST_WARN && d.st != ST_FAIL) d.code = `CODE_OFF;
    else if (err_out_a) d.code = `CODE_ERR_A;
    else if (err_out_b) d.code = `CODE_ERR_B;
    else if (cross_wire) d.code = `CODE_CROSS;
    else if (over_temp) d.code = `CODE_TEMP;
    else if (bad_actuator) d.code = `CODE_ACTR;
    else d.code = `CODE_OFF;

    // Serial bytes, rebuilt every cycle so the gateway copy never goes stale
    d.resp                = 8'h00;
    d.resp[`RSP_SAFE]     = d.safe;
    d.resp[`RSP_ACT]      = actuator_present;
    d.resp[`RSP_INP]      = safety_in_a & safety_in_b;
    d.resp[`RSP_LIM]      = run & limit_area;
    d.resp[`RSP_WARN]     = (d.st == ST_WARN);
    d.resp[`RSP_FAIL]     = (d.st == ST_FAIL);
    d.wf                  = 8'h00;
    d.wf[`WF_ERR_A]       = err_out_a;
    d.wf[`WF_ERR_B]       = err_out_b;
    d.wf[`WF_CROSS]       = cross_wire;
    d.wf[`WF_TEMP]        = over_temp;
    d.wf[`WF_ACTR]        = bad_actuator & (d.st == ST_FAIL);
    d.wf[`WF_INTL]        = internal_fail;
    d.wf[`WF_COMM]        = comm_err & (d.st != ST_FAIL);
    if (req_hit) d.req_last = req_byte;

    // Sticky events; a new event beats a clear in the same cycle
    ev             = '0;
    ev[`IRQ_WARN]  = (d.st == ST_WARN) && (q.st != ST_WARN);
    ev[`IRQ_FAIL]  = (d.st == ST_FAIL) && (q.st != ST_FAIL);
    ev[`IRQ_LIMIT] = limit_area & ~q.lim_seen;
    ev[`IRQ_FRST]  = frst;
    d.lim_seen     = limit_area;
    clr = (wr && paddr == `REG_ISTAT) ? pwdata[`IRQ_W-1:0] : '0;
    d.irq_stat = (q.irq_stat & ~clr) | ev;
    if (wr && paddr == `REG_IMASK) d.irq_mask = pwdata[`IRQ_W-1:0];
    d.irq = |(d.irq_stat & d.irq_mask);

    // APB: answer in the first access cycle, data fetched in setup
    d.pready  = psel & ~penable;
    d.pslverr = 1'b0;
    d.prdata  = 32'h0000_0000;
    if (psel && !penable) begin
      unique case (paddr)
        `REG_CTRL:   d.prdata = 32'h0000_0000;
        `REG_STATUS: d.prdata = {24'h00_0000, q.resp};
        `REG_WARN:   d.prdata = {24'h00_0000, q.wf};
        `REG_ISTAT:  d.prdata = {28'h000_0000, q.irq_stat};
        `REG_IMASK:  d.prdata = {28'h000_0000, q.irq_mask};
        `REG_REQ:    d.prdata = {24'h00_0000, q.req_last};
        default:     d.pslverr = 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      q    <= '0;
      q.st <= ST_IDLE;
    end else begin
      q <= d;
    end
  end

  // Red lamp timing lives in its own generator
  flash_gen #(
    .PULSE_CYC (PULSE_CYC),
    .GAP_CYC   (GAP_CYC)
  ) u_red (
    .clock (clock),
    .rstn  (rstn),
    .code  (q.code),
    .led   (red_led)
  );

  // Every output except red_led is a flop of the state record
  assign prdata       = q.prdata;
  assign pready       = q.pready;
  assign pslverr      = q.pslverr;
  assign irq          = q.irq;
  assign resp_byte    = q.resp;
  assign wf_byte      = q.wf;
  assign green_led    = q.green;
  assign yellow_led   = q.yellow;
  assign diag_out     = q.diag;
  assign safety_out_a = q.safe;
  assign safety_out_b = q.safe;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  green_ready_a: assert property (@(posedge clock) disable iff (!rstn)
    green_led |-> (q.st == ST_IDLE || q.st == ST_RUN))
    else $error("green lit outside ready states");

  yellow_range_a: assert property (@(posedge clock) disable iff (!rstn)
    (actuator_present && !limit_area) |=> yellow_led)
    else $error("yellow dark with actuator in range");

  red_steady_a: assert property (@(posedge clock) disable iff (!rstn)
    internal_fail [*3] |-> red_led)
    else $error("red not steady on internal failure");

  diag_drop_a: assert property (@(posedge clock) disable iff (!rstn)
    (q.st == ST_RUN && fault && !hard) |=> (!diag_out && q.st == ST_WARN))
    else $error("diagnostic output not dropped on fault");

  shutdown_end_a: assert property (@(posedge clock) disable iff (!rstn)
    (q.st == ST_WARN && fault && q.tmr == SHUTDOWN_CYC - 1'b1)
      |=> (q.st == ST_FAIL && !safety_out_a && !safety_out_b))
    else $error("channels not off after shutdown delay");

  warn_hold_a: assert property (@(posedge clock) disable iff (!rstn)
    (q.st == ST_WARN) |-> (!diag_out && safety_out_a == safety_out_b))
    else $error("diagnostic output high during warning");

  idle_off_a: assert property (@(posedge clock) disable iff (!rstn)
    (q.st == ST_IDLE) |-> (!safety_out_a && !diag_out && !resp_byte[`RSP_WARN]))
    else $error("outputs live without actuator");

  intl_off_a: assert property (@(posedge clock) disable iff (!rstn)
    $past(internal_fail) |-> (!green_led && yellow_led && !safety_out_a && !diag_out))
    else $error("internal failure pattern wrong");

  status_fail_a: assert property (@(posedge clock) disable iff (!rstn)
    resp_byte[`RSP_FAIL] |-> (!resp_byte[`RSP_SAFE] && !safety_out_a))
    else $error("failure reported with outputs enabled");

  status_safe_a: assert property (@(posedge clock) disable iff (!rstn)
    resp_byte[`RSP_SAFE] == safety_out_a)
    else $error("status bit 0 differs from safety outputs");

  wf_intl_a: assert property (@(posedge clock) disable iff (!rstn)
    wf_byte[`WF_INTL] == $past(internal_fail))
    else $error("internal failure bit wrong");

  limit_diag_a: assert property (@(posedge clock) disable iff (!rstn)
    (q.st == ST_RUN && $past(limit_area) && $past(act_ok)) |-> (diag_out == $past(q.tog)))
    else $error("diagnostic output not cycling in limit area");

  chain_skip_a: assert property (@(posedge clock) disable iff (!rstn)
    (req_valid && (req_addr != chain_pos || chain_pos == 5'h00))
      |=> (q.req_last == $past(q.req_last)))
    else $error("request taken by wrong chain position");

  fail_latch_a: assert property (@(posedge clock) disable iff (!rstn)
    (q.st == ST_FAIL && !frst) |=> (q.st == ST_FAIL))
    else $error("failure left without reset request");

  wf_fail_a: assert property (@(posedge clock) disable iff (!rstn)
    wf_byte[`WF_ACTR] |-> (q.st == ST_FAIL && !wf_byte[`WF_COMM]))
    else $error("actuator error bit outside failure");

  status_combo_a: assert property (@(posedge clock) disable iff (!rstn)
    resp_byte[`RSP_SAFE]
      |-> (resp_byte[`RSP_ACT] && resp_byte[`RSP_INP] && !resp_byte[`RSP_FAIL]))
    else $error("status bits inconsistent with released outputs");

  red_dark_a: assert property (@(posedge clock) disable iff (!rstn)
    (q.st == ST_IDLE || q.st == ST_RUN) |=> !red_led)
    else $error("red lit without a fault");

  resp_fresh_a: assert property (@(posedge clock) disable iff (!rstn)
    resp_byte[`RSP_ACT] == $past(actuator_present))
    else $error("status byte not refreshed");

  warn_channels_a: assert property (@(posedge clock) disable iff (!rstn)
    (q.st == ST_RUN && fault && !hard && act_ok)
      |=> (safety_out_a && safety_out_b && q.st == ST_WARN))
    else $error("channels dropped on entering warning");
endmodule

// ### bench/gateway_model.sv
// Gateway model: sends request bytes, collects the sensor input byte
`timescale 1ns/1ns
module gateway_model (
  // Clock
  input  wire logic       clock,
  // Chain side
  input  wire logic [7:0] resp_byte,
  output logic            req_valid,
  output logic [4:0]      req_addr,
  output logic [7:0]      req_byte,
  // Collected input byte
  output logic [7:0]      seen
);
  initial begin
    req_valid = 1'b0;
    req_addr  = 5'h00;
    req_byte  = 8'h00;
  end
  ////////////////////////////////////////////////
  // Input byte taken every cycle, never polled
  always @(posedge clock) seen <= resp_byte;
  // One request pulse; released fields are scrambled so stale data cannot pass
  task automatic send(input logic [4:0] a, input logic [7:0] b);
    @(posedge clock);
    req_valid <= 1'b1;
    req_addr  <= a;
    req_byte  <= b;
    @(posedge clock);
    req_valid <= 1'b0;
    req_addr  <= ~a;
    req_byte  <= ~b;
  endtask
endmodule

// ### bench/testbench.sv
// Self-checking bench of the safety sensor diagnostics block
`timescale 1ns/1ns
`include "ssd_cfg.svh"
module testbench;
  // Short timings keep the run brief
  localparam int SHUT  = 50;
  localparam int PULSE = 3;
  localparam int GAP   = 10;
  localparam int TOG   = 4;
  logic        clock   = 1'b0;
  logic        rstn    = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, irq;
  logic        actuator_present = 1'b0, limit_area = 1'b0, comm_err = 1'b0;
  logic        safety_in_a = 1'b0, safety_in_b = 1'b0, internal_fail = 1'b0;
  logic [4:0]  faults = 5'h00;
  logic [4:0]  chain_pos = 5'h1f;
  logic        req_valid;
  logic [4:0]  req_addr;
  logic [7:0]  req_byte, resp_byte, wf_byte, seen;
  logic        green_led, red_led, yellow_led, diag_out, safety_out_a, safety_out_b;
  int          fails = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  safety_sensor_diagnostics #(
    .SHUTDOWN_CYC(`TMR_W'(SHUT)), .PULSE_CYC(`CNT_W'(PULSE)),
    .GAP_CYC(`CNT_W'(GAP)), .TOGGLE_CYC(`CNT_W'(TOG))
  ) safety_sensor_diagnostics_inst (
    .clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq, .actuator_present, .limit_area, .safety_in_a, .safety_in_b,
    .err_out_a(faults[0]), .err_out_b(faults[1]), .cross_wire(faults[2]),
    .over_temp(faults[3]), .bad_actuator(faults[4]), .internal_fail, .comm_err,
    .chain_pos, .req_valid, .req_addr, .req_byte, .resp_byte, .wf_byte,
    .green_led, .red_led, .yellow_led, .diag_out, .safety_out_a, .safety_out_b
  );
  gateway_model gateway_model_inst (
    .clock, .resp_byte, .req_valid, .req_addr, .req_byte, .seen
  );

  ////////////////////////////////////////////////
  // Clock and a hang guard
  always #10 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      test_done;
    end
  end
  task automatic test_done;
    if (fails == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Land on a falling edge so registered outputs have settled
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  // Green and yellow lamps, diag and both channels as one vector, then the status byte
  task automatic look(input logic [4:0] exp, input logic [7:0] r, input string what);
    chk({green_led, yellow_led, diag_out, safety_out_a, safety_out_b}, 32'(exp), what);
    chk(resp_byte, 32'(r), what);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Count pulses between two gaps; the gap is a low run longer than the pulse spacing
  task automatic red_count(input int n);
    int cnt, low, ph, k;
    cnt = 0;
    low = 0;
    ph = 0;
    k = 0;
    while (ph < 2 && k < 150) begin
      settle(0);
      k++;
      if (red_led === 1'b1) begin
        if (ph == 1 && low > 0) cnt++;
        low = 0;
      end else low++;
      if (low == PULSE + 2) ph++;
    end
    chk(cnt, n, "red pulses");
  endtask
  task automatic clear_fail;
    logic [31:0] rd;
    logic err;
    @(posedge clock);
    faults <= 5'h00;
    apb(1'b1, `REG_CTRL, 32'h1, rd, err);
    settle(3);
    look(5'b11111, 8'h13, "after reset");
  endtask

  ////////////////////////////////////////////////
  task automatic idle_state;
    settle(2);
    look(5'b10000, 8'h00, "idle");
    chk(red_led, 1'b0, "idle red");
  endtask
  task automatic actuated;
    logic [31:0] rd;
    logic err;
    @(posedge clock);
    actuator_present <= 1'b1;
    safety_in_a <= 1'b1;
    safety_in_b <= 1'b1;
    settle(2);
    look(5'b11111, 8'h13, "actuated");
    chk(seen, 8'h13, "gateway byte");
    apb(1'b0, `REG_STATUS, 32'h0, rd, err);
    chk(rd, 32'h13, "status read");
    apb(1'b0, 8'h18, 32'h0, rd, err);
    chk(err, 1'b1, "unmapped err");
    chk(rd, 32'h0, "unmapped data");
  endtask
  task automatic limit_blink;
    int ny, nd;
    logic y, d;
    logic [31:0] rd;
    logic err;
    @(posedge clock);
    limit_area <= 1'b1;
    settle(2);
    chk(resp_byte, 8'h33, "limit status");
    apb(1'b0, `REG_ISTAT, 32'h0, rd, err);
    chk(rd, 32'h4, "limit event");
    ny = 0;
    nd = 0;
    y = yellow_led;
    d = diag_out;
    repeat (2 * TOG) begin
      settle(0);
      ny += int'(yellow_led !== y);
      nd += int'(diag_out !== d);
      y = yellow_led;
      d = diag_out;
      chk({safety_out_a, safety_out_b}, 2'b11, "limit channels");
    end
    chk(ny, 2, "yellow blink");
    chk(nd, 2, "diag cyclic");
    @(posedge clock);
    limit_area <= 1'b0;
  endtask
  task automatic comm_fault;
    @(posedge clock);
    comm_err <= 1'b1;
    settle(2);
    chk(wf_byte, 8'h40, "comm bit");
    chk(resp_byte, 8'h13, "comm status");
    @(posedge clock);
    comm_err <= 1'b0;
  endtask
  // Warning holds channels on until the delay runs out; only the unmasked failure event raises the interrupt
  task automatic warn_shutdown;
    logic [31:0] rd;
    logic err;
    apb(1'b1, `REG_ISTAT, 32'hf, rd, err);
    apb(1'b1, `REG_IMASK, 32'h2, rd, err);
    @(posedge clock);
    faults <= 5'h01;
    settle(1);
    look(5'b01011, 8'h53, "warning");
    chk(irq, 1'b0, "masked irq");
    settle(SHUT - 6);
    chk({diag_out, safety_out_a}, 2'b01, "delay running");
    settle(10);
    look(5'b01000, 8'h92, "failure");
    chk(irq, 1'b1, "fail irq");
    apb(1'b0, `REG_ISTAT, 32'h0, rd, err);
    chk(rd, 32'h3, "event bits");
    apb(1'b1, `REG_ISTAT, 32'h2, rd, err);
    settle(1);
    chk(irq, 1'b0, "irq cleared");
    clear_fail;
    apb(1'b0, `REG_ISTAT, 32'h0, rd, err);
    chk(rd, 32'h9, "reset event");
  endtask
  task automatic flash_codes;
    for (int n = 1; n <= 5; n++) begin
      @(posedge clock);
      faults <= 5'(1 << (n - 1));
      settle(3);
      chk(wf_byte, 32'(1 << (n - 1)), "fault bit");
      red_count(n);
      clear_fail;
    end
  endtask
  task automatic internal_failure;
    logic [31:0] rd;
    logic err;
    @(posedge clock);
    internal_fail <= 1'b1;
    settle(3);
    look(5'b01000, 8'h92, "internal");
    chk(wf_byte, 8'h20, "internal bit");
    settle(2 * GAP);
    chk(red_led, 1'b1, "steady red");
    @(posedge clock);
    internal_fail <= 1'b0;
    gateway_model_inst.send(5'd30, 8'h80);
    settle(3);
    chk(resp_byte, 8'h92, "foreign request");
    gateway_model_inst.send(5'd31, 8'h80);
    settle(3);
    look(5'b11111, 8'h13, "serial reset");
    apb(1'b0, `REG_REQ, 32'h0, rd, err);
    chk(rd, 32'h80, "request byte");
  endtask

  initial begin
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    idle_state;
    actuated;
    limit_blink;
    comm_fault;
    warn_shutdown;
    flash_codes;
    internal_failure;
    test_done;
  end
endmodule
